// [tbt_defines.svh]
// Register map, field positions and bus response codes of the time base and timers
`ifndef TBT_DEFINES_SVH
`define TBT_DEFINES_SVH
`define TBT_ADDR_W 6
`define TBT_OFF_CTRL 6'h00
`define TBT_OFF_TB_LO 6'h04
`define TBT_OFF_TB_HI 6'h08
`define TBT_OFF_PIT_LOAD 6'h0c
`define TBT_OFF_PIT_CNT 6'h10
`define TBT_OFF_INT_STAT 6'h14
`define TBT_OFF_INT_MASK 6'h18
`define TBT_OFF_WDOG_KIND 6'h1c
`define TBT_CTRL_EXT_SEL 0
`define TBT_CTRL_RELOAD 1
`define TBT_CTRL_FIT_LO 2
`define TBT_CTRL_FIT_HI 3
`define TBT_CTRL_WDG_LO 4
`define TBT_CTRL_WDG_HI 5
`define TBT_CTRL_WDG_EN 6
`define TBT_ST_PIT 0
`define TBT_ST_FIT 1
`define TBT_ST_WDG 2
`define TBT_FIT_B0 9
`define TBT_FIT_B1 13
`define TBT_FIT_B2 17
`define TBT_FIT_B3 21
`define TBT_WDG_B0 17
`define TBT_WDG_B1 21
`define TBT_WDG_B2 25
`define TBT_WDG_B3 29
`define TBT_RESP_OKAY 2'h0
`define TBT_RESP_SLVERR 2'h2
`endif

// [tbt_pkg.sv]
// Types shared by the time base and timer block
package tbt_pkg;
  typedef struct packed {
    logic ext_sel;
    logic reload;
    logic [1:0] fit_sel;
    logic [1:0] wdg_sel;
    logic wdg_en;
  } tbt_ctrl_t;
  typedef enum logic [1:0] {
    TBT_RST_NONE,
    TBT_RST_CORE,
    TBT_RST_CHIP,
    TBT_RST_SYSTEM
  } tbt_rst_kind_t;
endpackage

// [tbt_rise_det.sv]
// Rising-edge detector on one of four selected time-base bits
`timescale 1ns/100ps
module tbt_rise_det #(
  parameter int B0 = 0,
  parameter int B1 = 1,
  parameter int B2 = 2,
  parameter int B3 = 3
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic [1:0] sel,
  input wire logic [63:0] tb,
  output logic rise
);
  logic prev_q;
  logic prev_d;
  logic bit_now;

  always_comb begin
    case (sel)
      2'h0: bit_now = tb[B0];
      2'h1: bit_now = tb[B1];
      2'h2: bit_now = tb[B2];
      default: bit_now = tb[B3];
    endcase
    prev_d = tick ? bit_now : prev_q;
    // Selector change can look like an edge; accepted, matches a real bit flip
    rise = tick & bit_now & ~prev_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule

// [tbt_timers.sv]
// Time base, interval, fixed-period and watchdog timers with AXI4-Lite registers
`timescale 1ns/100ps
`include "tbt_defines.svh"
module tbt_timers
  import tbt_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic timer_zone_clock_enable,
  input wire logic ext_tick,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic wdg_reset_req,
  output tbt_rst_kind_t wdg_reset_kind
);
  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  logic aw_hold_q, aw_hold_d;
  logic w_hold_q, w_hold_d;
  logic [5:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic wr_fire;
  logic wr_hit;

  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ~w_hold_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    aw_addr_d = aw_addr_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? `TBT_RESP_OKAY : `TBT_RESP_SLVERR;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= `TBT_RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      aw_addr_q <= aw_addr_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  assign wr_fire = aw_hold_q & w_hold_q;

  // Byte-lane merge of the held write data onto an old register value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Registers and timers
  // ---------------------------------------------------------------
  tbt_ctrl_t ctrl_q, ctrl_d;
  tbt_rst_kind_t kind_q, kind_d;
  logic [63:0] tb_q, tb_d;
  logic [31:0] pit_load_q, pit_load_d;
  logic [31:0] pit_cnt_q, pit_cnt_d;
  logic [2:0] stat_q, stat_d;
  logic [2:0] mask_q, mask_d;
  logic wdg_req_q, wdg_req_d;
  logic tick;
  logic fit_rise;
  logic wdg_rise;
  logic pit_hit;
  logic [31:0] ctrl_word;
  logic [31:0] wr_ctrl;
  logic [2:0] clr;

  // External tick is taken as synchronous to clk
  assign tick = timer_zone_clock_enable & (ctrl_q.ext_sel ? ext_tick : 1'b1);

  assign ctrl_word = {25'h0, ctrl_q.wdg_en, ctrl_q.wdg_sel, ctrl_q.fit_sel,
                      ctrl_q.reload, ctrl_q.ext_sel};
  assign wr_ctrl = merge(ctrl_word, w_data_q, w_strb_q);

  always_comb begin
    wr_hit = 1'b1;
    case (aw_addr_q)
      `TBT_OFF_CTRL, `TBT_OFF_TB_LO, `TBT_OFF_TB_HI, `TBT_OFF_PIT_LOAD,
      `TBT_OFF_PIT_CNT, `TBT_OFF_INT_STAT, `TBT_OFF_INT_MASK, `TBT_OFF_WDOG_KIND: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Time base and interval timer both step on one tick only
  assign pit_hit = tick && (pit_cnt_q == 32'h1);

  always_comb begin
    ctrl_d = ctrl_q;
    kind_d = kind_q;
    tb_d = tb_q;
    pit_load_d = pit_load_q;
    pit_cnt_d = pit_cnt_q;
    mask_d = mask_q;
    clr = 3'h0;
    if (tick) begin
      tb_d = tb_q + 64'h1;
      if (pit_cnt_q != 32'h0) begin
        pit_cnt_d = pit_cnt_q - 32'h1;
        if (pit_cnt_q == 32'h1 && ctrl_q.reload) begin
          pit_cnt_d = pit_load_q;
        end
      end
      // At zero without reload the counter parks and fires no more
    end
    if (wr_fire) begin
      case (aw_addr_q)
        `TBT_OFF_CTRL: begin
          ctrl_d.ext_sel = wr_ctrl[`TBT_CTRL_EXT_SEL];
          ctrl_d.reload = wr_ctrl[`TBT_CTRL_RELOAD];
          ctrl_d.fit_sel = wr_ctrl[`TBT_CTRL_FIT_HI:`TBT_CTRL_FIT_LO];
          ctrl_d.wdg_sel = wr_ctrl[`TBT_CTRL_WDG_HI:`TBT_CTRL_WDG_LO];
          ctrl_d.wdg_en = wr_ctrl[`TBT_CTRL_WDG_EN];
        end
        `TBT_OFF_TB_LO: tb_d[31:0] = merge(tb_q[31:0], w_data_q, w_strb_q);
        `TBT_OFF_TB_HI: tb_d[63:32] = merge(tb_q[63:32], w_data_q, w_strb_q);
        `TBT_OFF_PIT_LOAD: begin
          pit_load_d = merge(pit_load_q, w_data_q, w_strb_q);
          pit_cnt_d = pit_load_d;
        end
        `TBT_OFF_INT_STAT: clr = w_data_q[2:0] & {3{w_strb_q[0]}};
        `TBT_OFF_INT_MASK: begin
          if (w_strb_q[0]) begin
            mask_d = w_data_q[2:0];
          end
        end
        `TBT_OFF_WDOG_KIND: begin
          if (w_strb_q[0]) begin
            kind_d = tbt_rst_kind_t'(w_data_q[1:0]);
          end
        end
        default: ;
      endcase
    end
    // Hardware set beats a same-cycle software clear
    stat_d = (stat_q & ~clr);
    stat_d[`TBT_ST_PIT] = stat_d[`TBT_ST_PIT] | pit_hit;
    stat_d[`TBT_ST_FIT] = stat_d[`TBT_ST_FIT] | fit_rise;
    stat_d[`TBT_ST_WDG] = stat_d[`TBT_ST_WDG] | (wdg_rise & ctrl_q.wdg_en);
    // Request stays high until software clears the watchdog flag
    wdg_req_d = stat_d[`TBT_ST_WDG];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= '0;
      kind_q <= TBT_RST_NONE;
      tb_q <= '0;
      pit_load_q <= '0;
      pit_cnt_q <= '0;
      stat_q <= '0;
      mask_q <= '0;
      wdg_req_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      kind_q <= kind_d;
      tb_q <= tb_d;
      pit_load_q <= pit_load_d;
      pit_cnt_q <= pit_cnt_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      wdg_req_q <= wdg_req_d;
    end
  end

  tbt_rise_det #(
    .B0(`TBT_FIT_B0),
    .B1(`TBT_FIT_B1),
    .B2(`TBT_FIT_B2),
    .B3(`TBT_FIT_B3)
  ) u_fit (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .sel(ctrl_q.fit_sel),
    .tb(tb_d),
    .rise(fit_rise)
  );

  tbt_rise_det #(
    .B0(`TBT_WDG_B0),
    .B1(`TBT_WDG_B1),
    .B2(`TBT_WDG_B2),
    .B3(`TBT_WDG_B3)
  ) u_wdg (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .sel(ctrl_q.wdg_sel),
    .tb(tb_d),
    .rise(wdg_rise)
  );

  assign irq = |(stat_q[`TBT_ST_FIT:`TBT_ST_PIT] & mask_q[`TBT_ST_FIT:`TBT_ST_PIT]);
  assign wdg_reset_req = wdg_req_q & (kind_q != TBT_RST_NONE);
  assign wdg_reset_kind = kind_q;

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = `TBT_RESP_OKAY;
      case (s_axi_araddr)
        `TBT_OFF_CTRL: rdata_d = ctrl_word;
        `TBT_OFF_TB_LO: rdata_d = tb_q[31:0];
        `TBT_OFF_TB_HI: rdata_d = tb_q[63:32];
        `TBT_OFF_PIT_LOAD: rdata_d = pit_load_q;
        `TBT_OFF_PIT_CNT: rdata_d = pit_cnt_q;
        `TBT_OFF_INT_STAT: rdata_d = {29'h0, stat_q};
        `TBT_OFF_INT_MASK: rdata_d = {29'h0, mask_q};
        `TBT_OFF_WDOG_KIND: rdata_d = {30'h0, kind_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = `TBT_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= `TBT_RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
endmodule

// [tbt_timers_monitor.sv]
// Bus handshake and timer output checks for tbt_timers
`timescale 1ns/100ps
module tbt_timers_monitor
  import tbt_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic timer_zone_clock_enable,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic irq,
  input wire logic wdg_reset_req,
  input wire tbt_rst_kind_t wdg_reset_kind
);
  // ------
  // Properties
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_bv; s_wr |-> ##2 s_axi_bvalid; endproperty
  property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_bk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_rv; s_rd |=> s_axi_rvalid; endproperty
  property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  property p_rk; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_wk; wdg_reset_req |-> wdg_reset_kind != TBT_RST_NONE; endproperty
  // Only a register write may take a raised output down again
  property p_ih; irq |=> irq || $rose(s_axi_bvalid); endproperty
  property p_wh; wdg_reset_req |=> wdg_reset_req || $rose(s_axi_bvalid); endproperty
  // Outputs may only rise from a tick or a register write
  property p_ev;
    $rose(irq) || $rose(wdg_reset_req) |-> $past(timer_zone_clock_enable) || $rose(s_axi_bvalid);
  endproperty
  a_bv: assert property (p_bv) else $error("write response late");
  a_bh: assert property (p_bh) else $error("write response dropped");
  a_bk: assert property (p_bk) else $error("write taken while busy");
  a_rv: assert property (p_rv) else $error("read response late");
  a_rh: assert property (p_rh) else $error("read response changed");
  a_rk: assert property (p_rk) else $error("read taken while busy");
  a_wk: assert property (p_wk) else $error("reset request without kind");
  a_ih: assert property (p_ih) else $error("interrupt dropped without write");
  a_wh: assert property (p_wh) else $error("reset request dropped without write");
  a_ev: assert property (p_ev) else $error("event without tick");
endmodule
bind tbt_timers tbt_timers_monitor i_mon (.*);

// [tbt_cpm_model.sv]
// Power management stand-in: timer zone gate and external tick source
`timescale 1ns/100ps
module tbt_cpm_model (
  input wire logic clk,
  input wire logic sleep_req,
  output logic timer_zone_clock_enable,
  output logic ext_tick
);
  logic [1:0] cnt_q;
  assign timer_zone_clock_enable = !sleep_req;
  // Phase restarts on wake so tick counts come out exact
  assign ext_tick = !sleep_req && cnt_q == 2'h3;
  always @(posedge clk) cnt_q <= sleep_req ? 2'h0 : cnt_q + 2'h1;
endmodule

// [time_base_and_timers_tb.sv]
// Register-level test of the time base and timers
`timescale 1ns/100ps
`include "tbt_defines.svh"
module time_base_and_timers_tb;
  import tbt_pkg::*;
  logic clk = 0, sys_rst = 1, sleep_req = 1, timer_zone_clock_enable, ext_tick;
  logic [5:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, wdg_reset_req;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  tbt_rst_kind_t wdg_reset_kind;
  int failures = 0, checks_done = 0;
  tbt_timers i_dut (.*);
  tbt_cpm_model i_cpm (.*);
  initial forever #5 clk = ~clk;
  // ------
  // Tasks
  // ------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    logic ta, tw, t;
    ta = 0;
    tw = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ta && tw)) begin
      @(negedge clk);
      ta |= s_axi_awready;
      tw |= s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    do begin
      @(negedge clk);
      t = s_axi_bvalid;
      wr_r = s_axi_bresp;
      @(posedge clk);
    end while (!t);
    s_axi_bready <= 1'h0;
  endtask
  task rd(input logic [5:0] a);
    logic t;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clk);
      t = s_axi_arready;
      @(posedge clk);
    end while (!t);
    s_axi_arvalid <= 1'h0;
    do begin
      @(negedge clk);
      t = s_axi_rvalid;
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      @(posedge clk);
    end while (!t);
    s_axi_rready <= 1'h0;
  endtask
  task rc(input logic [5:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_d, e);
  endtask
  // Opens the timer zone for exactly n clock cycles
  task run(input int n);
    @(posedge clk);
    sleep_req <= 1'h0;
    repeat (n) @(posedge clk);
    sleep_req <= 1'h1;
    @(negedge clk);
  endtask
  task close_out;
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    failures++;
    close_out();
  end
  // ------
  // Tests
  // ------
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    rd(`TBT_OFF_CTRL);
    chk(rd_d, 32'h0);
    chk(rd_r, `TBT_RESP_OKAY);
    rd(6'h20);
    chk(rd_r, `TBT_RESP_SLVERR);
    chk(rd_d, 32'h0);
    wr(6'h20, 32'h0);
    chk(wr_r, `TBT_RESP_SLVERR);
    wr(`TBT_OFF_PIT_CNT, 32'h5);
    chk(wr_r, `TBT_RESP_OKAY);
    rc(`TBT_OFF_PIT_CNT, 32'h0);
    wr(`TBT_OFF_TB_LO, 32'hffff_fffe);
    wr(`TBT_OFF_TB_HI, 32'h0);
    run(3);
    rc(`TBT_OFF_TB_LO, 32'h1);
    rc(`TBT_OFF_TB_HI, 32'h1);
    wr(`TBT_OFF_CTRL, 32'h1);
    wr(`TBT_OFF_TB_LO, 32'h0);
    wr(`TBT_OFF_PIT_LOAD, 32'h14);
    run(40);
    rc(`TBT_OFF_TB_LO, 32'ha);
    rc(`TBT_OFF_PIT_CNT, 32'ha);
    wr(`TBT_OFF_CTRL, 32'h0);
    wr(`TBT_OFF_INT_MASK, 32'h1);
    wr(`TBT_OFF_PIT_LOAD, 32'h5);
    run(2);
    rc(`TBT_OFF_PIT_CNT, 32'h3);
    chk(irq, 1'h0);
    run(3);
    chk(irq, 1'h1);
    run(3);
    rc(`TBT_OFF_PIT_CNT, 32'h0);
    chk(irq, 1'h1);
    wr(`TBT_OFF_INT_MASK, 32'h0);
    chk(irq, 1'h0);
    wr(`TBT_OFF_INT_MASK, 32'h1);
    wr(`TBT_OFF_INT_STAT, 32'h1);
    run(3);
    chk(irq, 1'h0);
    wr(`TBT_OFF_CTRL, 32'h2);
    wr(`TBT_OFF_PIT_LOAD, 32'h3);
    run(7);
    rc(`TBT_OFF_PIT_CNT, 32'h2);
    wr(`TBT_OFF_PIT_LOAD, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr(`TBT_OFF_WDOG_KIND, i);
      wr(`TBT_OFF_CTRL, 32'h40 | i << 4 | i << 2);
      wr(`TBT_OFF_TB_LO, (32'h1 << (`TBT_FIT_B0 + 4 * i)) - 32'h1);
      wr(`TBT_OFF_INT_STAT, 32'h7);
      run(1);
      rd(`TBT_OFF_INT_STAT);
      chk(rd_d[1], 1'h1);
      wr(`TBT_OFF_TB_LO, (32'h1 << (`TBT_WDG_B0 + 4 * i)) - 32'h1);
      wr(`TBT_OFF_INT_STAT, 32'h7);
      chk(wdg_reset_req, 1'h0);
      run(1);
      rd(`TBT_OFF_INT_STAT);
      chk(rd_d[2], 1'h1);
      chk(wdg_reset_req, i != 0);
      chk(wdg_reset_kind, i);
    end
    close_out();
  end
endmodule
